// >>> inc/rds_pkg.sv
// shared constants and types for the reset delay sequencer
package rds_pkg;

  // ==========================================================
  // clock and timing
  localparam int unsigned REF_CLK_HZ = 40_000_000;
  // delay times in microseconds, as specified
  localparam int unsigned POR_DELAY_US     = 72_000;
  localparam int unsigned DELAY_0P25MS_US  = 250;
  localparam int unsigned DELAY_18MS_US    = 18_000;
  localparam int unsigned DELAY_60MS_US    = 60_000;
  localparam int unsigned DELAY_1S_US      = 1_000_000;
  // derived cycle counts (all above 4096, so top parameters take these as defaults)
  localparam int unsigned POR_DELAY_CYC    = (REF_CLK_HZ / 1_000_000) * POR_DELAY_US;
  localparam int unsigned DELAY_0P25MS_CYC = (REF_CLK_HZ / 1_000_000) * DELAY_0P25MS_US;
  localparam int unsigned DELAY_18MS_CYC   = (REF_CLK_HZ / 1_000_000) * DELAY_18MS_US;
  localparam int unsigned DELAY_60MS_CYC   = (REF_CLK_HZ / 1_000_000) * DELAY_60MS_US;
  localparam int unsigned DELAY_1S_CYC     = (REF_CLK_HZ / 1_000_000) * DELAY_1S_US;

  // ==========================================================
  // delay reset timer geometry
  localparam int unsigned DRT_WIDTH   = 10;
  localparam int unsigned PRESC_WIDTH = 24;
  localparam logic [9:0]  DRT_FULL_TC  = 10'h3FF;
  localparam logic [9:0]  DRT_SHORT_TC = 10'h0FF;
  localparam int unsigned DRT_FULL_TICKS  = 1024;
  localparam int unsigned DRT_SHORT_TICKS = 256;

  // ==========================================================
  // program counter
  localparam int unsigned PC_WIDTH     = 12;
  localparam logic [11:0] RESET_VECTOR = 12'hFFF;

  // ==========================================================
  // fuse field encodings
  localparam logic [1:0] DLY_SEL_0P25MS = 2'h2;
  localparam logic [1:0] DLY_SEL_18MS   = 2'h3;
  localparam logic [1:0] DLY_SEL_60MS   = 2'h0;
  localparam logic [1:0] DLY_SEL_1S     = 2'h1;
  localparam logic [1:0] BOR_SEL_OFF    = 2'h0;
  localparam logic [1:0] BOR_SEL_2V2    = 2'h1;
  localparam logic [1:0] BOR_SEL_2V4    = 2'h2;
  localparam logic [1:0] BOR_SEL_4V1    = 2'h3;

  typedef struct packed {
    logic [1:0] reset_delay_period;
    logic [1:0] brownout_level_select;
  } rds_fuse_s;

  typedef struct packed {
    logic power_on;
    logic brownout;
    logic watchdog;
    logic master_clear;
    logic wakeup;
  } rds_cause_s;

  localparam rds_cause_s CAUSE_RESET = 5'h10;

  typedef enum logic [3:0] {
    ST_HOLD  = 4'h1,
    ST_COUNT = 4'h2,
    ST_RUN   = 4'h4,
    ST_SLEEP = 4'h8
  } rds_state_e;

endpackage

// >>> verilog/rds_delay_counter.sv
// prescaler plus 10-bit delay reset timer with selectable terminal count
`timescale 1ns/1ps
`default_nettype none

module rds_delay_counter (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        clear,
  input  wire logic [23:0] prescale,
  input  wire logic [9:0]  terminal,
  output logic             done
);

  logic [23:0] presc;
  logic [9:0]  delay_reset_timer;
  logic        tick;

  assign tick = (presc == prescale);

  // ==========================================================
  // prescaler
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      presc <= 24'h000000;
    end else if (clear || tick || done) begin
      presc <= 24'h000000;
    end else begin
      presc <= presc + 24'h000001;
    end
  end

  // ==========================================================
  // ripple count, held cleared by the caller while any reset request stands
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      delay_reset_timer <= 10'h000;
      done              <= 1'b0;
    end else if (clear) begin
      delay_reset_timer <= 10'h000;
      done              <= 1'b0;
    end else if (tick && !done) begin
      delay_reset_timer <= delay_reset_timer + 10'h001;
      done              <= (delay_reset_timer == terminal);
    end
  end

endmodule

`default_nettype wire

// >>> verilog/rds_reset_sequencer.sv
// reset latch, source collection and delay sequencing for the core
`timescale 1ns/1ps
`default_nettype none

module rds_reset_sequencer #(
  parameter int unsigned POR_CYC    = rds_pkg::POR_DELAY_CYC,
  parameter int unsigned D0P25_CYC  = rds_pkg::DELAY_0P25MS_CYC,
  parameter int unsigned D18_CYC    = rds_pkg::DELAY_18MS_CYC,
  parameter int unsigned D60_CYC    = rds_pkg::DELAY_60MS_CYC,
  parameter int unsigned D1S_CYC    = rds_pkg::DELAY_1S_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              master_clear_pin_n,
  input  wire logic              brownout_below,
  input  wire logic              watchdog_timeout,
  input  wire logic              power_down_req,
  input  wire rds_pkg::rds_fuse_s extended_fuse_word,
  output logic                   core_reset,
  output logic                   pc_load,
  output logic [11:0]            pc_reset_value,
  output logic                   wake_pulse,
  output logic [1:0]             brownout_level_select,
  output logic                   brownout_enable,
  output rds_pkg::rds_cause_s    reset_cause
);

  // ==========================================================
  // prescale per source: tick length so that the terminal count spans the period
  localparam logic [23:0] PRESC_POR   = 24'(POR_CYC / rds_pkg::DRT_FULL_TICKS - 1);
  localparam logic [23:0] PRESC_0P25  = 24'(D0P25_CYC / rds_pkg::DRT_SHORT_TICKS - 1);
  localparam logic [23:0] PRESC_18    = 24'(D18_CYC / rds_pkg::DRT_SHORT_TICKS - 1);
  localparam logic [23:0] PRESC_60    = 24'(D60_CYC / rds_pkg::DRT_SHORT_TICKS - 1);
  localparam logic [23:0] PRESC_1S    = 24'(D1S_CYC / rds_pkg::DRT_SHORT_TICKS - 1);

  function automatic logic [23:0] fuse_prescale(input logic [1:0] sel);
    case (sel)
      rds_pkg::DLY_SEL_0P25MS: fuse_prescale = PRESC_0P25;
      rds_pkg::DLY_SEL_18MS:   fuse_prescale = PRESC_18;
      rds_pkg::DLY_SEL_60MS:   fuse_prescale = PRESC_60;
      default:                 fuse_prescale = PRESC_1S;
    endcase
  endfunction

  // ==========================================================
  // pin synchronisers
  logic master_clear_pin_meta;
  logic master_clear_pin_sync;
  logic bor_meta;
  logic bor_sync;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      master_clear_pin_meta <= 1'b0;
      master_clear_pin_sync <= 1'b0;
      bor_meta  <= 1'b0;
      bor_sync  <= 1'b0;
    end else begin
      master_clear_pin_meta <= master_clear_pin_n;
      master_clear_pin_sync <= master_clear_pin_meta;
      bor_meta  <= brownout_below;
      bor_sync  <= bor_meta;
    end
  end

  // ==========================================================
  // brown-out threshold select, straight from the fuse bits
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      brownout_level_select <= rds_pkg::BOR_SEL_OFF;
      brownout_enable       <= 1'b0;
    end else begin
      brownout_level_select <= extended_fuse_word.brownout_level_select;
      brownout_enable       <= (extended_fuse_word.brownout_level_select
                                != rds_pkg::BOR_SEL_OFF);
    end
  end

  // ==========================================================
  // reset request collection
  logic bor_active;
  logic master_clear_pin_low;
  logic hold_req;

  assign bor_active = bor_sync && brownout_enable;
  assign master_clear_pin_low   = !master_clear_pin_sync;
  // a watchdog pulse lands in hold for one cycle, then counting restarts
  assign hold_req   = bor_active || master_clear_pin_low || watchdog_timeout;

  // ==========================================================
  // state machine
  rds_pkg::rds_state_e state;
  rds_pkg::rds_state_e next_state;
  logic                por_pending;
  logic                drt_clear;
  logic                drt_done;
  logic [23:0]         drt_prescale;
  logic [9:0]          drt_terminal;

  always_comb begin
    next_state = state;
    case (state)
      rds_pkg::ST_HOLD: begin
        if (!hold_req) begin
          next_state = rds_pkg::ST_COUNT;
        end
      end
      rds_pkg::ST_COUNT: begin
        if (hold_req) begin
          next_state = rds_pkg::ST_HOLD;
        end else if (drt_done) begin
          next_state = rds_pkg::ST_RUN;
        end
      end
      rds_pkg::ST_RUN: begin
        if (hold_req) begin
          next_state = rds_pkg::ST_HOLD;
        end else if (power_down_req) begin
          next_state = rds_pkg::ST_SLEEP;
        end
      end
      rds_pkg::ST_SLEEP: begin
        if (hold_req) begin
          next_state = rds_pkg::ST_HOLD;
        end else if (drt_done) begin
          next_state = rds_pkg::ST_RUN;
        end
      end
      default: next_state = rds_pkg::ST_HOLD;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= rds_pkg::ST_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // power-on flag survives until the first release
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      por_pending <= 1'b1;
    end else if (state == rds_pkg::ST_COUNT && next_state == rds_pkg::ST_RUN) begin
      por_pending <= 1'b0;
    end
  end

  // ==========================================================
  // delay reset timer
  // cleared whenever not counting, so every re-entry restarts from zero
  assign drt_clear = (state == rds_pkg::ST_HOLD) || (state == rds_pkg::ST_RUN)
                     || hold_req;

  always_comb begin
    if (por_pending && state != rds_pkg::ST_SLEEP) begin
      drt_prescale = PRESC_POR;
      drt_terminal = rds_pkg::DRT_FULL_TC;
    end else begin
      drt_prescale = fuse_prescale(extended_fuse_word.reset_delay_period);
      drt_terminal = rds_pkg::DRT_SHORT_TC;
    end
  end

  rds_delay_counter u_drt (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .clear    (drt_clear),
    .prescale (drt_prescale),
    .terminal (drt_terminal),
    .done     (drt_done)
  );

  // ==========================================================
  // reset latch and program counter load
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_reset <= 1'b1;
    end else if (next_state == rds_pkg::ST_HOLD || next_state == rds_pkg::ST_COUNT) begin
      core_reset <= 1'b1;
    end else begin
      core_reset <= 1'b0;
    end
  end

  // wake from power-down vectors the core too, without a full reset hold
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_load        <= 1'b1;
      pc_reset_value <= rds_pkg::RESET_VECTOR;
      wake_pulse     <= 1'b0;
    end else begin
      pc_load        <= (next_state == rds_pkg::ST_HOLD) || (next_state == rds_pkg::ST_COUNT)
                        || (state == rds_pkg::ST_SLEEP && next_state == rds_pkg::ST_RUN);
      pc_reset_value <= rds_pkg::RESET_VECTOR;
      wake_pulse     <= (state == rds_pkg::ST_SLEEP && next_state == rds_pkg::ST_RUN);
    end
  end

  // ==========================================================
  // cause of the most recent reset or wake, replaced on each new entry to hold and on each wake from sleep
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_cause <= rds_pkg::CAUSE_RESET;
    end else if (state == rds_pkg::ST_SLEEP && next_state == rds_pkg::ST_RUN) begin
      reset_cause <= 5'h01;
    end else if (state != rds_pkg::ST_HOLD && next_state == rds_pkg::ST_HOLD) begin
      reset_cause.power_on     <= 1'b0;
      reset_cause.brownout     <= bor_active;
      reset_cause.watchdog     <= watchdog_timeout;
      reset_cause.master_clear <= master_clear_pin_low;
      reset_cause.wakeup       <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// >>> verification/rds_reset_sequencer_properties.sv
// concurrent checks on the reset delay sequencer ports
`timescale 1ns/1ps
`default_nettype none

module rds_reset_sequencer_properties #(
  parameter int unsigned MIN_HOLD = 256
) (
  input wire logic               ref_clk,
  input wire logic               rst_n,
  input wire logic               master_clear_pin_n,
  input wire logic               brownout_below,
  input wire logic               watchdog_timeout,
  input wire logic               power_down_req,
  input wire rds_pkg::rds_fuse_s extended_fuse_word,
  input wire logic               core_reset,
  input wire logic               pc_load,
  input wire logic [11:0]        pc_reset_value,
  input wire logic               wake_pulse,
  input wire logic [1:0]         brownout_level_select,
  input wire logic               brownout_enable,
  input wire rds_pkg::rds_cause_s reset_cause
);
  // ==========================================
  // helper: length of the current reset hold
  logic [15:0] hold_cnt;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt <= 16'h0000;
    end else if (!core_reset) begin
      hold_cnt <= 16'h0000;
    end else if (hold_cnt != 16'hFFFF) begin
      hold_cnt <= hold_cnt + 16'h0001;
    end
  end

  // ==========================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_pc_vector_top: assert property (pc_reset_value == 12'hFFF)
    else $error("pc reset value is not the top word");
  a_reset_loads_pc: assert property (core_reset |-> pc_load)
    else $error("pc not loaded while in reset");
  a_wdt_sets_latch: assert property (watchdog_timeout |=> core_reset)
    else $error("watchdog did not set the latch");
  a_pin_low_holds: assert property (!master_clear_pin_n [*4] |=> core_reset)
    else $error("latch clear while pin low");
  a_bor_holds: assert property ((brownout_below && brownout_enable) [*4] |=> core_reset)
    else $error("latch clear while supply low");
  a_bor_level_copy: assert property (##1 brownout_level_select
    == $past(extended_fuse_word.brownout_level_select))
    else $error("brownout level not taken from fuse");
  a_bor_enable_map: assert property (brownout_enable == (brownout_level_select != 2'h0))
    else $error("brownout enable wrong");
  a_release_min_hold: assert property ($fell(core_reset) |-> $past(hold_cnt) >= MIN_HOLD)
    else $error("release before the timer ran");
  a_release_pin_high: assert property ($fell(core_reset) |-> $past(master_clear_pin_n, 4))
    else $error("release without the pin high");
  a_wake_vectors: assert property (wake_pulse |-> pc_load && !core_reset
    && reset_cause == 5'h01 ##1 !wake_pulse)
    else $error("wake pulse malformed");

  c_release: cover property ($fell(core_reset));
  c_wake: cover property (wake_pulse);
  c_wdt: cover property (watchdog_timeout && !core_reset);
endmodule

`default_nettype wire

// >>> verification/rds_master_clear_pin_model.sv
// external reset circuit pulling the master clear pin low on request
`timescale 1ns/1ps
`default_nettype none

module rds_master_clear_pin_model (
  input  wire logic ref_clk,
  input  wire logic hold_low,
  output logic      master_clear_pin_n
);
  // one process drives the pin: low from time zero, then follows the request
  initial begin
    master_clear_pin_n = 1'b0;
    forever begin
      @(posedge ref_clk);
      master_clear_pin_n <= #2 !hold_low;
    end
  end
endmodule

`default_nettype wire

// >>> verification/rds_reset_sequencer_tb.sv
// self-checking bench for the reset delay sequencer
`timescale 1ns/1ps
`default_nettype none

module rds_reset_sequencer_tb;
  localparam int POR = 4096;
  logic               ref_clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               master_clear_pin_req = 1'b1;
  logic               master_clear_pin_n;
  logic               brownout_below = 1'b0;
  logic               watchdog_timeout = 1'b0;
  logic               power_down_req = 1'b0;
  rds_pkg::rds_fuse_s extended_fuse_word = 4'hC;
  logic               core_reset;
  logic               pc_load;
  logic [11:0]        pc_reset_value;
  logic               wake_pulse;
  logic [1:0]         brownout_level_select;
  logic               brownout_enable;
  rds_pkg::rds_cause_s reset_cause;
  int                 errors = 0;
  int                 comparisons = 0;
  int                 cycles = 0;
  int                 n;
  logic [1:0]         row_code [4] = '{2'h2, 2'h3, 2'h0, 2'h1};
  int                 row_cyc [4] = '{512, 1024, 1536, 2048};

  rds_master_clear_pin_model i_master_clear_pin (.ref_clk(ref_clk), .hold_low(master_clear_pin_req),
    .master_clear_pin_n(master_clear_pin_n));
  rds_reset_sequencer #(.POR_CYC(POR), .D0P25_CYC(512), .D18_CYC(1024),
    .D60_CYC(1536), .D1S_CYC(2048)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .master_clear_pin_n(master_clear_pin_n), .brownout_below(brownout_below),
    .watchdog_timeout(watchdog_timeout), .power_down_req(power_down_req),
    .extended_fuse_word(extended_fuse_word), .core_reset(core_reset),
    .pc_load(pc_load), .pc_reset_value(pc_reset_value), .wake_pulse(wake_pulse),
    .brownout_level_select(brownout_level_select),
    .brownout_enable(brownout_enable), .reset_cause(reset_cause));

  always #12.5 ref_clk = ~ref_clk;

  task automatic close_out;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      close_out();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s exp %0h got %0h", name, exp, got);
    end
  endtask

  // delays are checked in a window: sync stages add a few cycles
  task automatic near(input string name, input int exp, input int got);
    comparisons++;
    if (got < exp - 2 || got > exp + 16) begin
      errors++;
      $display("[ERR] %s exp %0d got %0d", name, exp, got);
    end
  endtask

  task automatic wait_for(input bit wake, output int cnt);
    cnt = 0;
    while (cnt < 10000) begin
      @(posedge ref_clk);
      #1;
      cnt++;
      if (wake ? (wake_pulse === 1'b1) : (core_reset === 1'b0)) break;
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  initial begin
    tick(16);
    chk("core_reset", 32'h1, core_reset);
    chk("pc_reset_value", 32'hFFF, pc_reset_value);
    chk("reset_cause", 32'h10, reset_cause);
    rst_n <= 1'b1;
    tick(200);
    chk("core_reset", 32'h1, core_reset);
    master_clear_pin_req <= 1'b0;
    wait_for(1'b0, n);
    near("por_release", POR + 4, n);
    for (int i = 0; i < 4; i++) begin
      extended_fuse_word.reset_delay_period <= row_code[i];
      tick(4);
      power_down_req <= 1'b1;
      tick(1);
      power_down_req <= 1'b0;
      wait_for(1'b1, n);
      near("wake_delay", row_cyc[i], n);
      chk("wake_pc_load", 32'h1, pc_load);
      chk("wake_cause", 32'h01, reset_cause);
      tick(4);
      watchdog_timeout <= 1'b1;
      tick(1);
      watchdog_timeout <= 1'b0;
      wait_for(1'b0, n);
      near("wdt_release", row_cyc[i], n);
      chk("wdt_cause", 32'h04, reset_cause);
    end
    extended_fuse_word <= 4'hD;
    tick(4);
    chk("bor_level", 32'h1, brownout_level_select);
    chk("bor_enable_on", 32'h1, brownout_enable);
    brownout_below <= 1'b1;
    tick(300);
    chk("bor_hold", 32'h1, core_reset);
    brownout_below <= 1'b0;
    wait_for(1'b0, n);
    near("bor_release", 1024 + 2, n);
    chk("bor_cause", 32'h08, reset_cause);
    extended_fuse_word.brownout_level_select <= 2'h0;
    tick(4);
    brownout_below <= 1'b1;
    tick(50);
    chk("bor_off_reset", 32'h0, core_reset);
    chk("bor_enable", 32'h0, brownout_enable);
    brownout_below <= 1'b0;
    master_clear_pin_req <= 1'b1;
    tick(20);
    master_clear_pin_req <= 1'b0;
    wait_for(1'b0, n);
    near("master_clear_pin_release", 1024 + 4, n);
    chk("master_clear_pin_cause", 32'h02, reset_cause);
    // a watchdog inside the count must start the delay over
    watchdog_timeout <= 1'b1;
    tick(1);
    watchdog_timeout <= 1'b0;
    tick(300);
    chk("wdt_mid_hold", 32'h1, core_reset);
    watchdog_timeout <= 1'b1;
    tick(1);
    watchdog_timeout <= 1'b0;
    wait_for(1'b0, n);
    near("wdt_restart", 1024, n);
    // reset in mid-run brings back the full power-on count
    rst_n <= 1'b0;
    tick(4);
    chk("rst_core_reset", 32'h1, core_reset);
    chk("rst_cause", 32'h10, reset_cause);
    rst_n <= 1'b1;
    wait_for(1'b0, n);
    near("por_again", POR + 4, n);
    close_out();
  end
endmodule

bind rds_reset_sequencer rds_reset_sequencer_properties #(.MIN_HOLD(256)) i_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .master_clear_pin_n(master_clear_pin_n),
  .brownout_below(brownout_below), .watchdog_timeout(watchdog_timeout),
  .power_down_req(power_down_req), .extended_fuse_word(extended_fuse_word),
  .core_reset(core_reset), .pc_load(pc_load), .pc_reset_value(pc_reset_value),
  .wake_pulse(wake_pulse), .brownout_level_select(brownout_level_select),
  .brownout_enable(brownout_enable), .reset_cause(reset_cause));

`default_nettype wire
